// file: rtl/spr_ctrl_regs.sv
// serial port control register bank with transmit fifo and link shifters
// assumes a cpu data-memory port on mclk_i and an external serial partner
`timescale 1ns/10ps
module spr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
  wire pop = out_ready_i && (cnt_q != '0);
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= AW'(wr_q + 1'b1);
      if (pop)
        rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end
endmodule // spr_fifo

module spr_ctrl_regs
  import spr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // cpu data-memory port
  input wire logic [15:0] dm_addr_i,
  input wire logic [15:0] dm_wdata_i,
  input wire logic dm_we_i,
  input wire logic [1:0] dm_op_i,
  input wire logic dm_re_i,
  output logic [15:0] dm_rdata_o,
  output logic dm_busy_o,
  output logic tx_full_o,
  // serial link pins
  input wire logic serial_xmit_clock_pin_i,
  output logic serial_xmit_clock_pin_o,
  output logic serial_xmit_clock_pin_oe_n_o,
  output logic dx_o,
  output logic fsx_o,
  input wire logic dr_i,
  input wire logic fsr_i
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] tx_hold_q;
  logic [15:0] rx_data_q;
  logic bl_pend_q;
  spr_op_e bl_op_q;
  logic [15:0] bl_mask_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic full_q;
  // full address compare: the registers sit only in data page zero
  wire hit_rx = (dm_addr_i == ADDR_RX);
  wire hit_tx = (dm_addr_i == ADDR_TX);
  wire hit_ctrl = (dm_addr_i == ADDR_CTRL);
  wire take = !bl_pend_q;
  wire ctrl_store = take && dm_we_i && hit_ctrl && (spr_op_e'(dm_op_i) == OP_STORE);
  wire ctrl_bl = take && dm_we_i && hit_ctrl && (spr_op_e'(dm_op_i) != OP_STORE);
  wire tx_wr = take && dm_we_i && hit_tx && fifo_in_ready;
  wire rx_wr = take && dm_we_i && hit_rx;
  wire [15:0] rd_mux = hit_ctrl ? ctrl_q : hit_tx ? tx_hold_q : hit_rx ? rx_data_q : 16'h0000;
  wire fmt_short = ctrl_q[BIT_FORMAT];
  wire clk_out_mode = ctrl_q[BIT_CLKDIR];
  wire [15:0] ctrl_bl_new = spr_apply(bl_op_q, ctrl_q, bl_mask_q);
  wire [15:0] ctrl_st_new = spr_apply(OP_STORE, ctrl_q, dm_wdata_i);
  logic rx_done;
  logic [15:0] rx_word;
  // bit-logic writes latch the operation and mask in the first cycle, then read and write the mode bits in the second
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_q <= CTRL_RST;
      bl_pend_q <= 1'b0;
      bl_op_q <= OP_STORE;
      bl_mask_q <= 16'h0000;
      tx_hold_q <= 16'h0000;
      dm_rdata_o <= 16'h0000;
      full_q <= 1'b0;
    end
    else
    begin
      bl_pend_q <= ctrl_bl;
      if (ctrl_bl)
      begin
        bl_op_q <= spr_op_e'(dm_op_i);
        bl_mask_q <= dm_wdata_i;
      end
      if (bl_pend_q)
        ctrl_q <= ctrl_bl_new;
      else if (ctrl_store)
        ctrl_q <= ctrl_st_new;
      if (tx_wr)
        tx_hold_q <= dm_wdata_i;
      if (take && dm_re_i)
        dm_rdata_o <= rd_mux;
      full_q <= !fifo_in_ready;
    end
  end
  // receive register: a finished link word wins over a cpu store in the same cycle
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rx_data_q <= 16'h0000;
    else if (rx_done)
      rx_data_q <= rx_word;
    else if (rx_wr)
      rx_data_q <= dm_wdata_i;
  end
  assign dm_busy_o = bl_pend_q;
  assign tx_full_o = full_q;
  // ----------------------------------------
  // transmit fifo
  // ----------------------------------------
  logic tx_load;
  spr_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(tx_wr),
    .in_ready_o(fifo_in_ready),
    .in_data_i(dm_wdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tx_load),
    .out_data_o(fifo_out_data)
  );
  // ----------------------------------------
  // link clock: generate or sample
  // ----------------------------------------
  logic serial_xmit_clock_pin_s1_q;
  logic serial_xmit_clock_pin_s2_q;
  logic dr_s1_q;
  logic dr_s2_q;
  logic fsr_s1_q;
  logic fsr_s2_q;
  logic [1:0] div_q;
  logic gen_q;
  logic lclk_prev_q;
  logic oe_n_q;
  wire lclk = clk_out_mode ? gen_q : serial_xmit_clock_pin_s2_q;
  wire lrise = lclk && !lclk_prev_q;
  wire lfall = !lclk && lclk_prev_q;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_xmit_clock_pin_s1_q <= 1'b0;
      serial_xmit_clock_pin_s2_q <= 1'b0;
      dr_s1_q <= 1'b0;
      dr_s2_q <= 1'b0;
      fsr_s1_q <= 1'b0;
      fsr_s2_q <= 1'b0;
      div_q <= 2'h0;
      gen_q <= 1'b0;
      lclk_prev_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      serial_xmit_clock_pin_s1_q <= serial_xmit_clock_pin_i;
      serial_xmit_clock_pin_s2_q <= serial_xmit_clock_pin_s1_q;
      dr_s1_q <= dr_i;
      dr_s2_q <= dr_s1_q;
      fsr_s1_q <= fsr_i;
      fsr_s2_q <= fsr_s1_q;
      // a full period spans four machine cycles
      div_q <= (div_q == 2'(LINK_HALF_CYC - 1)) ? 2'h0 : 2'(div_q + 1'b1);
      if (div_q == 2'(LINK_HALF_CYC - 1))
        gen_q <= !gen_q;
      lclk_prev_q <= lclk;
      oe_n_q <= !clk_out_mode;
    end
  end
  assign serial_xmit_clock_pin_o = gen_q;
  assign serial_xmit_clock_pin_oe_n_o = oe_n_q;
  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  spr_txst_e st_q;
  logic [15:0] tsh_q;
  logic [4:0] tcnt_q;
  logic dx_q;
  logic fsx_q;
  wire [4:0] wlen = fmt_short ? 5'(WORD_SHORT) : 5'(WORD_LONG);
  wire [15:0] tload = fmt_short ? {fifo_out_data[7:0], 8'h00} : fifo_out_data;
  wire tx_end = (st_q == TX_SHIFT) && (tcnt_q == 5'h00);
  // words leave only while transmit mode frames them internally
  assign tx_load = lrise && fifo_out_valid && ctrl_q[BIT_TXMODE] && ((st_q == TX_IDLE) || tx_end);
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q <= TX_IDLE;
      tsh_q <= 16'h0000;
      tcnt_q <= 5'h00;
      dx_q <= 1'b0;
      fsx_q <= 1'b0;
    end
    else if (lrise)
    begin
      fsx_q <= tx_load;
      if (tx_load)
      begin
        st_q <= TX_SHIFT;
        tsh_q <= {tload[14:0], 1'b0};
        dx_q <= tload[15];
        tcnt_q <= 5'(wlen - 5'h01);
      end
      else
      begin
        case (st_q)
          TX_SHIFT:
          begin
            if (tx_end)
              st_q <= TX_IDLE;
            else
              tcnt_q <= 5'(tcnt_q - 1'b1);
            tsh_q <= {tsh_q[14:0], 1'b0};
            dx_q <= tsh_q[15];
          end
          default: st_q <= TX_IDLE;
        endcase
      end
    end
  end
  assign dx_o = dx_q;
  assign fsx_o = fsx_q;
  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  logic [15:0] rsh_q;
  logic [4:0] rcnt_q;
  wire [15:0] rsh_new = {rsh_q[14:0], dr_s2_q};
  wire [4:0] rcnt_base = fsr_s2_q ? 5'h00 : rcnt_q;
  assign rx_done = lfall && (5'(rcnt_base + 1'b1) == wlen);
  assign rx_word = fmt_short ? {8'h00, rsh_new[7:0]} : rsh_new;
  // a frame pulse realigns the word, so a glitch costs at most one word
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rsh_q <= 16'h0000;
      rcnt_q <= 5'h00;
    end
    else if (lfall)
    begin
      rsh_q <= rsh_new;
      rcnt_q <= rx_done ? 5'h00 : 5'(rcnt_base + 1'b1);
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_bl_req;
    !bl_pend_q && dm_we_i && hit_ctrl && (dm_op_i != 2'h0);
  endsequence
  sequence s_bl_done;
    bl_pend_q ##1 !bl_pend_q;
  endsequence
  AST_BL_TWO_CYCLES: assert property (@(posedge mclk_i) disable iff (!nrst_i) s_bl_req |=> s_bl_done)
    else $error("bit-logic write did not complete in two cycles");
  AST_OR_SETS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    bl_pend_q && bl_op_q == OP_OR |=> ctrl_q == (($past(ctrl_q) | $past(bl_mask_q)) & CTRL_IMPL_MASK))
    else $error("or-write result wrong");
  AST_AND_CLEARS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    bl_pend_q && bl_op_q == OP_AND |=> ctrl_q == ($past(ctrl_q) & $past(bl_mask_q)))
    else $error("and-write result wrong");
  AST_XOR_TOGGLES: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    bl_pend_q && bl_op_q == OP_XOR |=> ctrl_q == (($past(ctrl_q) ^ $past(bl_mask_q)) & CTRL_IMPL_MASK))
    else $error("xor-write result wrong");
  AST_CTRL_STABLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !bl_pend_q && !(dm_we_i && hit_ctrl) |=> $stable(ctrl_q))
    else $error("mode bits changed without a control write");
  AST_CTRL_READBACK: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !bl_pend_q && dm_re_i && hit_ctrl |=> dm_rdata_o == $past(ctrl_q))
    else $error("control read did not return mode bits");
  AST_OE_FOLLOWS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    ##1 serial_xmit_clock_pin_oe_n_o == !$past(ctrl_q[BIT_CLKDIR]))
    else $error("clock pin direction mismatch");
  AST_QUARTER_RATE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $changed(gen_q) |=> $stable(gen_q) ##1 $changed(gen_q))
    else $error("generated clock not at quarter rate");
  AST_TX_DECODE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !bl_pend_q && dm_we_i && hit_tx && !tx_full_o && fifo_in_ready
    |=> tx_hold_q == $past(dm_wdata_i))
    else $error("transmit data write lost");
endmodule // spr_ctrl_regs

// file: rtl/spr_pkg.sv
// constants, types and helpers of the serial port control register bank
// assumes a single machine clock domain and a 16-bit data-memory port
package spr_pkg;
  // ----------------------------------------
  // data-memory map
  // ----------------------------------------
  localparam logic [15:0] ADDR_RX = 16'h0020;
  localparam logic [15:0] ADDR_TX = 16'h0021;
  localparam logic [15:0] ADDR_CTRL = 16'h0022;
  // ----------------------------------------
  // control register layout and reset
  // ----------------------------------------
  localparam int BIT_FORMAT = 2;
  localparam int BIT_FSYNC = 3;
  localparam int BIT_TXMODE = 5;
  localparam int BIT_CLKDIR = 6;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'h006c;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MCLK_PERIOD_NS = 5;
  localparam int LINK_DIV = 4;
  localparam int LINK_HALF_CYC = LINK_DIV / 2;
  localparam int BL_OP_CYCLES = 2;
  localparam int WORD_LONG = 16;
  localparam int WORD_SHORT = 8;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {OP_STORE = 2'h0, OP_OR = 2'h1, OP_AND = 2'h2, OP_XOR = 2'h3} spr_op_e;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SHIFT = 2'h1} spr_txst_e;
  // mode bits after a store or bit-logic operation; unimplemented bits stay zero
  function automatic logic [15:0] spr_apply(input spr_op_e op, input logic [15:0] cur, input logic [15:0] mask);
    logic [15:0] r;
    r = cur;
    case (op)
      OP_STORE: r = mask;
      OP_OR: r = cur | mask;
      OP_AND: r = cur & mask;
      OP_XOR: r = cur ^ mask;
      default: r = cur;
    endcase
    return r & CTRL_IMPL_MASK;
  endfunction
endpackage

// file: tb/spr_link_partner.sv
// serial partner: clocks frames into the port and captures the words it sends
// assumes the testbench resolves the transmit clock wire from both drivers
`timescale 1ns/10ps
module spr_link_partner (
  // link pins
  input wire logic link_clk_i,
  input wire logic dx_i,
  input wire logic fsx_i,
  output logic clk_o = 1'b0,
  output logic dr_o = 1'b0,
  output logic fsr_o = 1'b0,
  // captured word, got_o toggles per word
  output logic [15:0] word_o = 16'h0000,
  output logic got_o = 1'b0
);
  int cnt = 0;
  logic [15:0] sh = 16'h0000;
  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  // clock stands still between frames; data goes to the inverse of its last bit
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      clk_o = 1'b1;
      dr_o = w[i];
      fsr_o = (i == 15);
      #62.5;
      clk_o = 1'b0;
      #62.5;
    end
    dr_o = ~w[0];
  endtask
  // ----------------------------------------
  // capture, sampled on the falling edge, msb first
  // ----------------------------------------
  always @(negedge link_clk_i)
  begin
    if (fsx_i === 1'b1 || cnt > 0)
    begin
      sh = {sh[14:0], dx_i};
      cnt = (fsx_i === 1'b1) ? 1 : cnt + 1;
    end
    if (cnt == 16)
    begin
      word_o = sh;
      got_o = ~got_o;
      cnt = 0;
    end
  end
endmodule // spr_link_partner

// file: tb/testbench.sv
// self-checking bench for the serial port control register bank
// assumes page 0 addressing and the partner model on the link pins
`timescale 1ns/10ps
module testbench
  import spr_pkg::*;
;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [15:0] dm_addr_i = 16'h0000;
  logic [15:0] dm_wdata_i = 16'h0000;
  logic dm_we_i = 1'b0;
  logic [1:0] dm_op_i = 2'h0;
  logic dm_re_i = 1'b0;
  logic [15:0] dm_rdata_o;
  logic dm_busy_o, tx_full_o, serial_xmit_clock_pin_o, serial_xmit_clock_pin_oe_n_o, dx_o, fsx_o;
  logic p_clk, p_dr, p_fsr, p_got;
  logic [15:0] p_word;
  wire logic link_clk = serial_xmit_clock_pin_oe_n_o ? p_clk : serial_xmit_clock_pin_o;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h09c6;
  logic rd_pend = 1'b0;
  logic [15:0] ctrl_m = 16'h0000;
  logic [15:0] rq[$];
  logic [15:0] tq[$];
  logic [15:0] masks [6] = '{16'h0004, 16'h0008, 16'h0020, 16'hfffb, 16'hfff7, 16'hffdf};
  always #2.5 mclk_i = ~mclk_i;
  spr_ctrl_regs DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .dm_addr_i(dm_addr_i), .dm_wdata_i(dm_wdata_i),
    .dm_we_i(dm_we_i), .dm_op_i(dm_op_i), .dm_re_i(dm_re_i), .dm_rdata_o(dm_rdata_o), .dm_busy_o(dm_busy_o),
    .tx_full_o(tx_full_o), .serial_xmit_clock_pin_i(link_clk), .serial_xmit_clock_pin_o(serial_xmit_clock_pin_o), .serial_xmit_clock_pin_oe_n_o(serial_xmit_clock_pin_oe_n_o), .dx_o(dx_o),
    .fsx_o(fsx_o), .dr_i(p_dr), .fsr_i(p_fsr));
  spr_link_partner PTR (.link_clk_i(link_clk), .dx_i(dx_o), .fsx_i(fsx_o), .clk_o(p_clk), .dr_o(p_dr),
    .fsr_o(p_fsr), .word_o(p_word), .got_o(p_got));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // bus tasks, expected values noted in queues
  // ----------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] op);
    @(posedge mclk_i);
    dm_addr_i <= a;
    dm_wdata_i <= d;
    dm_op_i <= op;
    dm_we_i <= 1'b1;
    @(posedge mclk_i);
    dm_we_i <= 1'b0;
    if (a == ADDR_CTRL)
      ctrl_m = CTRL_IMPL_MASK & ((op == 2'h0) ? d : (op == 2'h1) ? (ctrl_m | d) :
        (op == 2'h2) ? (ctrl_m & d) : (ctrl_m ^ d));
    if (op != 2'h0)
    begin
      @(negedge mclk_i);
      check({15'h0000, dm_busy_o}, 16'h0001);
      @(posedge mclk_i);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge mclk_i);
    dm_addr_i <= a;
    dm_re_i <= 1'b1;
    @(posedge mclk_i);
    dm_re_i <= 1'b0;
  endtask
  // ----------------------------------------
  // watchers
  // ----------------------------------------
  always @(posedge mclk_i)
    rd_pend <= dm_re_i & ~dm_busy_o;
  always @(negedge mclk_i)
    if (rd_pend)
      check(dm_rdata_o, (rq.size() > 0) ? rq.pop_front() : ~dm_rdata_o);
  always @(p_got)
    if (nrst_i)
      check(p_word, (tq.size() > 0) ? tq.pop_front() : ~p_word);
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] w;
    logic [7:0] b;
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    check({15'h0000, serial_xmit_clock_pin_oe_n_o}, 16'h0001);
    rd(ADDR_CTRL, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_CTRL, masks[i], (i < 3) ? 2'h1 : 2'h2);
      rd(ADDR_CTRL, ctrl_m);
    end
    // random masks through every write kind
    for (int i = 0; i < 16; i++)
    begin
      w = $random(seed);
      wr(ADDR_CTRL, w, 2'(i % 4));
      rd(ADDR_CTRL, ctrl_m);
    end
    wr(ADDR_CTRL, 16'h0000, 2'h0);
    w = $random(seed);
    wr(16'h0020, w, 2'h0);
    rd(16'h0020, w);
    rd(16'h0023, 16'h0000);
    // fill while transmit is off; the ninth word must be dropped
    for (int i = 0; i < 9; i++)
    begin
      w = $random(seed);
      if (i < FIFO_DEPTH)
        tq.push_back(w);
      wr(16'h0021, w, 2'h0);
    end
    check({15'h0000, tx_full_o}, 16'h0001);
    wr(ADDR_CTRL, 16'h0020, 2'h1);
    for (int i = 0; i < 8; i++)
    begin
      w = $random(seed);
      PTR.send_word(w);
      rd(16'h0020, w);
    end
    for (int n = 0; n < 200 && tq.size() > 0; n++)
      @(posedge mclk_i);
    if (tq.size() > 0)
      miscompares++;
    check({15'h0000, tx_full_o}, 16'h0000);
    // short words: only the low byte of the last eight bits lands
    wr(ADDR_CTRL, 16'h0004, 2'h1);
    w = $random(seed);
    PTR.send_word(w);
    rd(ADDR_RX, {8'h00, w[7:0]});
    wr(ADDR_CTRL, 16'hfffb, 2'h2);
    // driven transmit clock at quarter rate
    wr(ADDR_CTRL, 16'h0040, 2'h1);
    repeat (2) @(negedge mclk_i);
    check({15'h0000, serial_xmit_clock_pin_oe_n_o}, 16'h0000);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge mclk_i);
      b[i] = serial_xmit_clock_pin_o;
    end
    check({15'h0000, b[7:4] === b[3:0] && b[3:0] inside {4'h3, 4'h6, 4'hc, 4'h9}}, 16'h0001);
    wr(ADDR_CTRL, 16'h0040, 2'h3);
    repeat (2) @(negedge mclk_i);
    check({15'h0000, serial_xmit_clock_pin_oe_n_o}, 16'h0001);
    rd(ADDR_CTRL, ctrl_m);
    repeat (3) @(posedge mclk_i);
    stop_test();
  end
endmodule // testbench
